// ### idf_map.svh
`ifndef IDF_MAP_SVH
`define IDF_MAP_SVH

// register byte offsets
`define IDF_REG_INPUT 8'h00
`define IDF_REG_OUTPUT 8'h04
`define IDF_REG_FILTER 8'h08
`define IDF_REG_IRQ_ENABLE 8'h0c
`define IDF_REG_EDGE_SEL 8'h10
`define IDF_REG_IRQ_STATUS 8'h14

// field layout
`define IDF_PORT0_LSB 0
`define IDF_PORT1_LSB 8
`define IDF_FILTER_W 5

// reset values
`define IDF_OUTPUT_RST 16'h0000
`define IDF_FILTER_RST 5'h00
`define IDF_IRQ_ENABLE_RST 16'h0000
`define IDF_EDGE_SEL_RST 16'h0000
`define IDF_IRQ_STATUS_RST 16'h0000

// sampling clock rate against the system clock, in MHz
`define IDF_CLK_MHZ 50
`define IDF_SAMPLE_MHZ 8
`define IDF_FILTER_MAX 5'h14

`endif

// ### idf_pkg.sv
package idf_pkg;

  typedef logic [15:0] idf_word_t;

  // one register access as seen by the slave
  typedef struct packed {
    logic [7:0] adr;
    logic we;
    logic [3:0] sel;
    logic [31:0] dat;
  } idf_wb_req_s;

  // bus slave phase
  typedef enum logic {
    IDF_BUS_IDLE,
    IDF_BUS_ACK
  } idf_bus_e;

endpackage

// ### idf_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "idf_map.svh"

// How it works
// - inputs form two bytes, bits 0..15
// - outputs driven from two bytes, bits 0..15
// - conducting input reads as one
// - output one turns transistor on
// - outputs reset to zero
// - output register reads back unchanged
// - level passes only after stable time
// - filter setting 0..20, zero bypasses
// - stable time is 2^n 8MHz periods
// - one filter setting for all inputs
// - every input interrupts on filtered edge
// - per-input enable, reset disabled
// - edge select picks rising or falling
// - edge selects reset to zero
// - status read clears status and request
// - status bits reset to zero
// - disabled input never sets status
module idf_top #(
  parameter int N_INPUTS = 16,
  parameter int CNT_W = 21
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic irq_o,
  input wire logic [15:0] isolated_input_pin_i,
  output logic [15:0] isolated_output_pin_o
);

  idf_pkg::idf_wb_req_s req;
  idf_pkg::idf_bus_e bus_state;
  logic access;
  logic wr;
  logic rd;

  idf_pkg::idf_word_t out_data;
  logic [`IDF_FILTER_W-1:0] filter_sel;
  idf_pkg::idf_word_t irq_enable;
  idf_pkg::idf_word_t edge_sel;
  idf_pkg::idf_word_t irq_status;
  idf_pkg::idf_word_t next_irq_status;
  idf_pkg::idf_word_t status_clear;
  idf_pkg::idf_word_t edge_event;

  idf_pkg::idf_word_t raw_in;
  idf_pkg::idf_word_t filt_in;
  idf_pkg::idf_word_t filt_prev;

  logic [5:0] phase;
  logic sample_tick;
  logic [CNT_W-1:0] stable_target;

  // merge a 16-bit write under the low two byte lanes
  function automatic idf_pkg::idf_word_t merge16(input idf_pkg::idf_word_t old,
                                                 input logic [31:0] dat,
                                                 input logic [3:0] sel);
    idf_pkg::idf_word_t res;
    res = old;
    if (sel[0]) begin
      res[7:0] = dat[7:0];
    end
    if (sel[1]) begin
      res[15:8] = dat[15:8];
    end
    return res;
  endfunction

  assign req = '{adr: wb_adr_i, we: wb_we_i, sel: wb_sel_i, dat: wb_dat_i};
  // one access per request: the ack cycle itself is never a second access
  assign access = wb_cyc_i && wb_stb_i && (bus_state == idf_pkg::IDF_BUS_IDLE);
  assign wr = access && req.we;
  assign rd = access && !req.we;

  // bus handshake: ack one cycle after the request, dropped the next cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bus_state <= idf_pkg::IDF_BUS_IDLE;
      wb_ack_o <= 1'b0;
    end else begin
      case (bus_state)
        idf_pkg::IDF_BUS_IDLE: begin
          if (access) begin
            bus_state <= idf_pkg::IDF_BUS_ACK;
            wb_ack_o <= 1'b1;
          end
        end
        idf_pkg::IDF_BUS_ACK: begin
          bus_state <= idf_pkg::IDF_BUS_IDLE;
          wb_ack_o <= 1'b0;
        end
        default: begin
          bus_state <= idf_pkg::IDF_BUS_IDLE;
          wb_ack_o <= 1'b0;
        end
      endcase
    end
  end

  // read data, captured with the ack; unmapped offsets read zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (rd) begin
      if (req.adr == `IDF_REG_INPUT) begin
        wb_dat_o <= {16'h0000, filt_in};
      end else if (req.adr == `IDF_REG_OUTPUT) begin
        wb_dat_o <= {16'h0000, out_data};
      end else if (req.adr == `IDF_REG_FILTER) begin
        wb_dat_o <= {27'h000_0000, filter_sel};
      end else if (req.adr == `IDF_REG_IRQ_ENABLE) begin
        wb_dat_o <= {16'h0000, irq_enable};
      end else if (req.adr == `IDF_REG_EDGE_SEL) begin
        wb_dat_o <= {16'h0000, edge_sel};
      end else if (req.adr == `IDF_REG_IRQ_STATUS) begin
        wb_dat_o <= {16'h0000, irq_status};
      end else begin
        wb_dat_o <= 32'h0000_0000;
      end
    end
  end

  // output latch
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      out_data <= `IDF_OUTPUT_RST;
    end else if (wr && req.adr == `IDF_REG_OUTPUT) begin
      // byte lanes map to port 0 and port 1
      out_data <= merge16(out_data, req.dat, req.sel);
    end
  end

  // a one turns the transistor on
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      isolated_output_pin_o <= `IDF_OUTPUT_RST;
    end else begin
      isolated_output_pin_o <= out_data;
    end
  end

  // filter setting, shared by every input
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      filter_sel <= `IDF_FILTER_RST;
    end else if (wr && req.adr == `IDF_REG_FILTER && req.sel[0]) begin
      filter_sel <= req.dat[`IDF_FILTER_W-1:0];
    end
  end

  // interrupt enable and edge select
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_enable <= `IDF_IRQ_ENABLE_RST;
    end else if (wr && req.adr == `IDF_REG_IRQ_ENABLE) begin
      irq_enable <= merge16(irq_enable, req.dat, req.sel);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      edge_sel <= `IDF_EDGE_SEL_RST;
    end else if (wr && req.adr == `IDF_REG_EDGE_SEL) begin
      edge_sel <= merge16(edge_sel, req.dat, req.sel);
    end
  end

  // 8 MHz sample enable from 50 MHz by a fractional accumulator;
  // ticks are 6 or 7 cycles apart but average exactly 8 MHz
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      phase <= 6'h00;
      sample_tick <= 1'b0;
    end else if (phase + 6'(`IDF_SAMPLE_MHZ) >= 6'(`IDF_CLK_MHZ)) begin
      phase <= phase + 6'(`IDF_SAMPLE_MHZ) - 6'(`IDF_CLK_MHZ);
      sample_tick <= 1'b1;
    end else begin
      phase <= phase + 6'(`IDF_SAMPLE_MHZ);
      sample_tick <= 1'b0;
    end
  end

  // stable time is 2^n sample periods
  assign stable_target = CNT_W'(1) << filter_sel;

  // conducting pin arrives as one and stays one
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      raw_in <= 16'h0000;
    end else begin
      raw_in <= isolated_input_pin_i;
    end
  end

  // one setting drives every per-input filter
  for (genvar i = 0; i < N_INPUTS; i++) begin : g_filt
    logic [CNT_W-1:0] stable_cnt;

    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        stable_cnt <= '0;
        filt_in[i] <= 1'b0;
      end else if (filter_sel == `IDF_FILTER_RST) begin
        stable_cnt <= '0;
        filt_in[i] <= raw_in[i];
      // a level that returns early restarts the count
      end else if (raw_in[i] == filt_in[i]) begin
        stable_cnt <= '0;
      end else if (sample_tick) begin
        // pass the new level after the full stable time
        if (stable_cnt + CNT_W'(1) >= stable_target) begin
          stable_cnt <= '0;
          filt_in[i] <= raw_in[i];
        end else begin
          stable_cnt <= stable_cnt + CNT_W'(1);
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      filt_prev <= 16'h0000;
    end else begin
      filt_prev <= filt_in;
    end
  end

  // edges taken from the filtered level
  // select one is falling, zero is rising
  assign edge_event = (~edge_sel & filt_in & ~filt_prev) | (edge_sel & ~filt_in & filt_prev);

  // a status read clears every bit; write-one also clears
  always_comb begin
    status_clear = 16'h0000;
    if (access && req.adr == `IDF_REG_IRQ_STATUS) begin
      if (req.we) begin
        status_clear = merge16(16'h0000, req.dat, req.sel);
      end else begin
        status_clear = 16'hffff;
      end
    end
  end

  // a new edge beats the clear in the same cycle
  assign next_irq_status = (irq_status & ~status_clear) | (edge_event & irq_enable);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_status <= `IDF_IRQ_STATUS_RST;
    end else begin
      irq_status <= next_irq_status;
    end
  end

  // request follows the status register exactly
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |next_irq_status;
    end
  end

endmodule // idf_top

`default_nettype wire

// ### idf_field_model.sv
`timescale 1ns/1ps
`default_nettype none
module idf_field_model (
  input wire logic [15:0] closed_i,
  input wire logic [15:0] load_on_i,
  output logic [15:0] pin_o,
  output logic [15:0] lamp_o
);
  assign pin_o = closed_i;
  assign lamp_o = load_on_i;
endmodule // idf_field_model
`default_nettype wire

// ### idf_checker.sv
`timescale 1ns/1ps
`default_nettype none
`include "idf_map.svh"
module idf_checker (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic irq_o,
  input wire logic [15:0] isolated_input_pin_i,
  input wire logic [15:0] isolated_output_pin_o
);
  logic req;
  logic en_seen;
  logic filt0;
  assign req = wb_cyc_i && wb_stb_i;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // conservative: any enable write lifts the no-interrupt guard
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      en_seen <= 1'b0;
      filt0 <= 1'b1;
    end else if (req && wb_we_i && !wb_ack_o) begin
      if (wb_adr_i == `IDF_REG_IRQ_ENABLE)
        en_seen <= 1'b1;
      if (wb_adr_i == `IDF_REG_FILTER)
        filt0 <= (wb_dat_i[4:0] == 5'h00);
    end
  end
  out_write_a: assert property (
    wb_ack_o && $past(wb_we_i && wb_adr_i == `IDF_REG_OUTPUT && wb_sel_i == 4'h3)
    |=> isolated_output_pin_o == $past(wb_dat_i[15:0], 2)) else $error("pins not written");
  readback_a: assert property (
    wb_ack_o && $past(!wb_we_i && wb_adr_i == `IDF_REG_OUTPUT)
    |-> wb_dat_o[15:0] == isolated_output_pin_o) else $error("bad readback");
  input_read_a: assert property (
    wb_ack_o && filt0 && $past(!wb_we_i && wb_adr_i == `IDF_REG_INPUT)
    && $past(isolated_input_pin_i, 5) == isolated_input_pin_i
    |-> wb_dat_o[15:0] == isolated_input_pin_i) else $error("bad input read");
  out_reset_a: assert property (disable iff (1'b0)
    $past(rst_i) |-> isolated_output_pin_o == 16'h0000 && !irq_o) else $error("reset state");
  irq_hold_a: assert property (
    irq_o && !req |=> irq_o) else $error("irq dropped");
  irq_clear_a: assert property (
    $fell(irq_o) |-> $past(req)) else $error("irq fell alone");
  irq_gate_a: assert property (
    !en_seen |-> !irq_o) else $error("irq while disabled");
  status_reset_a: assert property (
    wb_ack_o && !en_seen && $past(!wb_we_i && wb_adr_i == `IDF_REG_IRQ_STATUS)
    |-> wb_dat_o == 32'h0) else $error("status not zero");
  cover property ($rose(irq_o));
  cover property (irq_o && req);
  cover property (wb_ack_o && !filt0);
endmodule // idf_checker
bind idf_top idf_checker chk_u (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
  .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .irq_o, .isolated_input_pin_i,
  .isolated_output_pin_o);
`default_nettype wire

// ### isolated_digital_io_filter_irq_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "idf_map.svh"
module isolated_digital_io_filter_irq_tb_top;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic irq_o;
  logic [15:0] sw = 16'h0000;
  logic [15:0] isolated_input_pin_i;
  logic [15:0] isolated_output_pin_o;
  logic [15:0] lamps;
  logic [31:0] q;
  int failures = 0;
  int n_tests = 0;
  int cycles = 0;
  always #10 clk_i = ~clk_i;
  idf_top dut_u (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .irq_o, .isolated_input_pin_i, .isolated_output_pin_o);
  idf_field_model field_u (.closed_i(sw), .load_on_i(isolated_output_pin_o),
    .pin_o(isolated_input_pin_i), .lamp_o(lamps));
  task automatic wb_io(input logic [7:0] a, input logic w, input logic [3:0] s,
    input logic [15:0] d);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_sel_i <= s;
    wb_dat_i <= {16'h0000, d};
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e);
    wb_io(a, 1'b0, 4'h3, 16'h0000);
    chk(nm, e, q);
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    wb_io(a, 1'b1, 4'h3, d);
  endtask
  task automatic hold(input int n, input logic [15:0] v);
    sw <= v;
    repeat (n) @(posedge clk_i);
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // whole run needs well under 1500 cycles
  always @(posedge clk_i) begin
    cycles++;
    if (cycles > 4000) begin
      failures++;
      complete_run();
    end
  end
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    rd("output", `IDF_REG_OUTPUT, 32'h0);
    rd("filter", `IDF_REG_FILTER, 32'h0);
    rd("enable", `IDF_REG_IRQ_ENABLE, 32'h0);
    rd("edge", `IDF_REG_EDGE_SEL, 32'h0);
    rd("status", `IDF_REG_IRQ_STATUS, 32'h0);
    rd("unmapped", 8'h20, 32'h0);
    $display("test reset done");
    wr(`IDF_REG_OUTPUT, 16'ha55a);
    // upper byte only: lower byte must keep its value
    wb_io(`IDF_REG_OUTPUT, 1'b1, 4'h2, 16'h3cff);
    repeat (2) @(posedge clk_i);
    chk("lamps", 32'h3c5a, {16'h0, lamps});
    rd("readback", `IDF_REG_OUTPUT, 32'h3c5a);
    chk("lamps kept", 32'h3c5a, {16'h0, lamps});
    hold(4, 16'h8001);
    rd("bypass", `IDF_REG_INPUT, 32'h8001);
    $display("test ports done");
    wr(`IDF_REG_FILTER, 16'h0014);
    rd("filter max", `IDF_REG_FILTER, 32'h14);
    // n=3: 8 ticks, 45..51 clocks; a 30-clock glitch is too short
    wr(`IDF_REG_FILTER, 16'h0003);
    hold(30, 16'hffff);
    hold(80, 16'h8001);
    rd("glitch", `IDF_REG_INPUT, 32'h8001);
    hold(30, 16'h0f0f);
    rd("early", `IDF_REG_INPUT, 32'h8001);
    hold(60, 16'h0f0f);
    rd("settled", `IDF_REG_INPUT, 32'h0f0f);
    $display("test filter done");
    wr(`IDF_REG_FILTER, 16'h0000);
    hold(4, 16'h0000);
    wr(`IDF_REG_IRQ_ENABLE, 16'h0003);
    wr(`IDF_REG_EDGE_SEL, 16'h0002);
    hold(6, 16'h0001);
    chk("irq rise", 32'h1, {31'h0, irq_o});
    rd("status rise", `IDF_REG_IRQ_STATUS, 32'h0001);
    chk("irq cleared", 32'h0, {31'h0, irq_o});
    hold(6, 16'h0003);
    chk("wrong edge", 32'h0, {31'h0, irq_o});
    hold(6, 16'h0001);
    rd("status fall", `IDF_REG_IRQ_STATUS, 32'h0002);
    hold(6, 16'h0011);
    hold(6, 16'h0001);
    chk("masked irq", 32'h0, {31'h0, irq_o});
    rd("masked", `IDF_REG_IRQ_STATUS, 32'h0);
    // write-one clears only the bits it names
    hold(6, 16'h0000);
    hold(6, 16'h0001);
    wr(`IDF_REG_IRQ_STATUS, 16'h0002);
    chk("w1c other bit", 32'h1, {31'h0, irq_o});
    wr(`IDF_REG_IRQ_STATUS, 16'h0001);
    chk("w1c own bit", 32'h0, {31'h0, irq_o});
    rd("w1c status", `IDF_REG_IRQ_STATUS, 32'h0);
    // an edge landing in the read-clear cycle must survive it
    hold(6, 16'h0003);
    hold(1, 16'h0001);
    rd("clear cycle", `IDF_REG_IRQ_STATUS, 32'h0);
    chk("edge kept irq", 32'h1, {31'h0, irq_o});
    rd("edge kept", `IDF_REG_IRQ_STATUS, 32'h0002);
    $display("test interrupts done");
    // reset in mid-run brings the output, enable, edge and status registers back
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rd("rerst output", `IDF_REG_OUTPUT, 32'h0);
    chk("rerst lamps", 32'h0, {16'h0, lamps});
    rd("rerst enable", `IDF_REG_IRQ_ENABLE, 32'h0);
    rd("rerst edge", `IDF_REG_EDGE_SEL, 32'h0);
    rd("rerst status", `IDF_REG_IRQ_STATUS, 32'h0);
    rd("rerst input", `IDF_REG_INPUT, 32'h0001);
    $display("test reset again done");
    complete_run();
  end
endmodule // isolated_digital_io_filter_irq_tb_top
`default_nettype wire
